// ==== design/skip_and_control_flow_exec.v ====
// execution of conditional skips and system-control instructions
// assumes decode presents one instruction per op_valid pulse, with the
// memory or port operand already fetched, and a one-cycle stack read
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "skip_ctl_regs.vh"

module skip_and_control_flow_exec (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // instruction from decode
  input  wire        op_valid,
  input  wire [3:0]  op_code,
  input  wire        op_mem,
  input  wire [7:0]  imm,
  input  wire [7:0]  opnd,
  input  wire [2:0]  bit_sel,
  input  wire [11:0] target,
  input  wire [7:0]  mem_addr,
  output wire        op_ready,
  // data memory write-back
  output reg         mem_we,
  output reg  [7:0]  mem_waddr,
  output reg  [7:0]  mem_wdata,
  // stack memory
  output reg         stk_we,
  output reg         stk_re,
  output reg  [7:0]  stk_addr,
  output reg  [11:0] stk_wdata,
  input  wire [11:0] stk_rdata,
  // hooks to watchdog and interrupt controller
  output reg         wdt_clear,
  output reg         gie_set,
  output reg         op_done,
  output reg         skipped,
  // core state
  output wire [7:0]  acc,
  output wire [3:0]  flags,
  output wire [7:0]  sp,
  output wire [11:0] pc,
  // register port
  input  wire [3:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        we,
  input  wire        re,
  output reg  [7:0]  rdata
);

  // sequencer states; a return is the only two-cycle case
  localparam ST_IDLE = 1'h0;  // takes instructions
  localparam ST_RET  = 1'h1;  // waits for stack data

  // architectural state
  reg  [7:0]  acc_r;          // accumulator
  reg  [3:0]  flags_r;        // ov, ac, c, z
  reg  [7:0]  sp_r;           // stack pointer
  reg  [11:0] pc_r;           // program counter
  reg         skip_r;         // next instruction is squashed
  reg         state_r;        // sequencer state
  reg         iret_r;         // pending return is from interrupt

  // combinational results
  reg  [7:0]  opa;            // first alu operand
  reg  [7:0]  opb;            // second alu operand
  reg         sub;            // alu subtracts
  reg  [8:0]  sum9;           // full sum with carry
  reg  [7:0]  bb;             // operand after inversion
  reg  [7:0]  res;            // alu result
  reg         nib_cy;         // carry out of the low nibble
  reg  [3:0]  aflags;         // flags from the alu
  wire        tbit;           // selected bit of the operand

  // register port decode and status word
  reg         wr_acc;         // software writes the accumulator
  reg         wr_flags;       // software writes the flags
  reg         wr_sp;          // software writes the stack pointer
  reg         wr_pc_lo;       // software writes pc bits 7:0
  reg         wr_pc_hi;       // software writes pc bits 11:8
  reg  [7:0]  stat_word;      // live skip and busy bits

  // state seen by the rest of the core
  assign acc      = acc_r;
  assign flags    = flags_r;
  assign sp       = sp_r;
  assign pc       = pc_r;
  // busy while a return waits on the stack
  assign op_ready = (state_r == ST_IDLE);
  assign tbit     = opnd[bit_sel];

  // operand selection per instruction
  always @* begin
    // compares by default: accumulator minus immediate
    opa = acc_r;
    opb = imm;
    sub = 1'h1;
    case (op_code)
      `OP_CEQ, `OP_CNE: begin
        // memory or immediate as subtrahend
        opb = op_mem ? opnd : imm;
      end
      `OP_INCZ: begin
        // accumulator or memory byte plus one
        opa = op_mem ? opnd : acc_r;
        opb = `BYTE_ONE;
        sub = 1'h0;
      end
      `OP_DECZ: begin
        // accumulator or memory byte minus one
        opa = op_mem ? opnd : acc_r;
        opb = `BYTE_ONE;
      end
      default: begin
        // other codes leave the alu result unused
        opb = imm;
      end
    endcase
  end

  // shared adder; borrow shows as a set carry
  // subtraction adds the inverted operand plus one
  always @* begin
    bb   = sub ? ~opb : opb;
    sum9 = {1'h0, opa} + {1'h0, bb} + {8'h00, sub};
    res  = sum9[7:0];
    // carry into bit 4 recovered from the sum bit, no second adder
    nib_cy = opa[4] ^ bb[4] ^ sum9[4];
    aflags[`FLG_Z]  = (res == `BYTE_ZERO);
    aflags[`FLG_C]  = sum9[8] ^ sub;
    aflags[`FLG_AC] = nib_cy ^ sub;
    // signed overflow: like signs in, other sign out
    aflags[`FLG_OV] = (opa[7] == bb[7]) & (res[7] != opa[7]);
  end

  // software write decode; one target per strobe
  always @* begin
    // nothing selected unless the strobe is up
    wr_acc   = 1'h0;
    wr_flags = 1'h0;
    wr_sp    = 1'h0;
    wr_pc_lo = 1'h0;
    wr_pc_hi = 1'h0;
    if (we) begin
      if (addr == `REG_ACC) begin
        wr_acc = 1'h1;
      end else if (addr == `REG_FLAGS) begin
        wr_flags = 1'h1;
      end else if (addr == `REG_SP) begin
        wr_sp = 1'h1;
      end else if (addr == `REG_PC_LO) begin
        wr_pc_lo = 1'h1;
      end else if (addr == `REG_PC_HI) begin
        wr_pc_hi = 1'h1;
      end
      // status and unmapped offsets ignore writes
    end
  end

  // status word with fields at their named positions
  always @* begin
    // spare status bits read as zero
    stat_word = `BYTE_ZERO;
    stat_word[`STAT_SKIP] = skip_r;
    stat_word[`STAT_BUSY] = ~op_ready;
  end

  // main execution process
  always @(posedge clock) begin
    if (rst) begin
      // architectural state back to its reset values
      acc_r     <= `ACC_RST;
      flags_r   <= `FLAGS_RST;
      sp_r      <= `SP_RST;
      pc_r      <= `PC_RST;
      skip_r    <= 1'h0;
      state_r   <= ST_IDLE;
      iret_r    <= 1'h0;
      // outputs quiet until the first instruction
      mem_we    <= 1'h0;
      mem_waddr <= `BYTE_ZERO;
      mem_wdata <= `BYTE_ZERO;
      stk_we    <= 1'h0;
      stk_re    <= 1'h0;
      stk_addr  <= `SP_RST;
      stk_wdata <= `PC_RST;
      wdt_clear <= 1'h0;
      gie_set   <= 1'h0;
      op_done   <= 1'h0;
      skipped   <= 1'h0;
    end else begin
      // pulses default low
      mem_we    <= 1'h0;
      stk_we    <= 1'h0;
      stk_re    <= 1'h0;
      wdt_clear <= 1'h0;
      gie_set   <= 1'h0;
      op_done   <= 1'h0;
      skipped   <= 1'h0;
      // idle takes one instruction per cycle
      case (state_r)
        ST_IDLE: begin
          if (op_valid && skip_r) begin
            // squashed: only the pc moves on
            pc_r    <= pc_r + `PC_ONE;
            skip_r  <= 1'h0;
            skipped <= 1'h1;
            op_done <= 1'h1;
          end else if (op_valid) begin
            // most instructions fall through
            pc_r    <= pc_r + `PC_ONE;
            op_done <= 1'h1;
            case (op_code)
              `OP_CEQ: begin
                // equal operands leave a zero difference
                flags_r <= aflags;
                skip_r  <= aflags[`FLG_Z];
              end
              `OP_CNE: begin
                // any nonzero difference means unequal
                flags_r <= aflags;
                skip_r  <= ~aflags[`FLG_Z];
              end
              `OP_BCLR: begin
                // flags kept as they are
                skip_r <= ~tbit;
              end
              `OP_BSET: begin
                // flags kept as they are
                skip_r <= tbit;
              end
              `OP_INCZ, `OP_DECZ: begin
                // skip tests the written result, not the old value
                flags_r <= aflags;
                skip_r  <= aflags[`FLG_Z];
                if (op_mem) begin
                  // result back to the same byte
                  mem_we    <= 1'h1;
                  mem_waddr <= mem_addr;
                  mem_wdata <= res;
                end else begin
                  acc_r <= res;
                end
              end
              `OP_CALL: begin
                // push return address, then jump
                stk_we    <= 1'h1;
                stk_addr  <= sp_r;
                stk_wdata <= pc_r + `PC_ONE;
                sp_r      <= sp_r + `SP_STEP;
                pc_r      <= target;
              end
              `OP_GOTO: begin
                // full 12-bit target, no stack traffic
                pc_r <= target;
              end
              `OP_RETV, `OP_RET, `OP_IRET: begin
                // value first, then the normal return
                if (op_code == `OP_RETV) begin
                  acc_r <= imm;
                end
                sp_r     <= sp_r - `SP_STEP;
                stk_addr <= sp_r - `SP_STEP;
                stk_re   <= 1'h1;
                iret_r   <= (op_code == `OP_IRET);
                state_r  <= ST_RET;
                // done is reported when the pc lands
                op_done  <= 1'h0;
              end
              `OP_WDRST: begin
                // one-cycle pulse; the timer itself lies outside
                wdt_clear <= 1'h1;
              end
              `OP_NOP: begin
                // nothing but the pc advance
                skip_r <= 1'h0;
              end
              default: begin
                // unknown code acts as no operation
                skip_r <= 1'h0;
              end
            endcase
          end
        end
        ST_RET: begin
          // stack word arrives one cycle after the read
          // instructions offered now are refused through op_ready
          pc_r    <= stk_rdata;
          gie_set <= iret_r;
          iret_r  <= 1'h0;
          op_done <= 1'h1;
          state_r <= ST_IDLE;
        end
        default: begin
          // unreachable with a one-bit state
          state_r <= ST_IDLE;
        end
      endcase
      // software writes win over the instruction in the same cycle
      // a write also lands while a return waits on the stack
      if (wr_acc) begin
        acc_r <= wdata;
      end
      if (wr_flags) begin
        // upper data bits have no flag behind them
        flags_r <= wdata[3:0];
      end
      if (wr_sp) begin
        sp_r <= wdata;
      end
      if (wr_pc_lo) begin
        pc_r[7:0] <= wdata;
      end
      if (wr_pc_hi) begin
        // only four pc bits sit above the low byte
        pc_r[11:8] <= wdata[3:0];
      end
    end
  end

  // register read port, data one cycle after the strobe
  always @(posedge clock) begin
    if (rst) begin
      rdata <= `BYTE_ZERO;
    end else if (re) begin
      // decode follows the write map; status is read-only
      if (addr == `REG_ACC) begin
        rdata <= acc_r;
      end else if (addr == `REG_FLAGS) begin
        rdata <= {4'h0, flags_r};
      end else if (addr == `REG_SP) begin
        rdata <= sp_r;
      end else if (addr == `REG_PC_LO) begin
        rdata <= pc_r[7:0];
      end else if (addr == `REG_PC_HI) begin
        rdata <= {4'h0, pc_r[11:8]};
      end else if (addr == `REG_STAT) begin
        // live skip and busy state
        rdata <= stat_word;
      end else begin
        // unmapped reads as zero
        rdata <= `BYTE_ZERO;
      end
    end else begin
      // read data stand one cycle only
      rdata <= `BYTE_ZERO;
    end
  end

endmodule

// ==== design/skip_ctl_regs.vh ====
// constants for the skip and control-flow execution block
// assumes an 8-bit core with a 12-bit program counter and word stack
// Contract
// - compare equal, then skip next instruction
// - compare unequal, then skip next instruction
// - compares set flags like accumulator minus operand
// - bit clear skips next; flags untouched
// - bit set skips next; flags untouched
// - increment, write back, flags, skip on zero
// - decrement, write back, flags, skip on zero
// - call pushes pc plus one, sp up two
// - jump loads full pc, flags kept
// - return with value loads accumulator, then returns
// - interrupt return also enables interrupts after
// - no operation only advances pc
// - watchdog restart clears watchdog count only
`ifndef SKIP_CTL_REGS_VH
`define SKIP_CTL_REGS_VH

// instruction codes from decode
`define OP_NOP     4'h0
`define OP_CEQ     4'h1
`define OP_CNE     4'h2
`define OP_BCLR    4'h3
`define OP_BSET    4'h4
`define OP_INCZ    4'h5
`define OP_DECZ    4'h6
`define OP_CALL    4'h7
`define OP_GOTO    4'h8
`define OP_RETV    4'h9
`define OP_RET     4'hA
`define OP_IRET    4'hB
`define OP_WDRST   4'hC

// register bus offsets
`define REG_ACC    4'h0
`define REG_FLAGS  4'h1
`define REG_SP     4'h2
`define REG_PC_LO  4'h3
`define REG_PC_HI  4'h4
`define REG_STAT   4'h5

// flag bit positions
`define FLG_Z      0
`define FLG_C      1
`define FLG_AC     2
`define FLG_OV     3

// status bit positions
`define STAT_SKIP  0
`define STAT_BUSY  1

// reset values and steps
`define ACC_RST    8'h00
`define FLAGS_RST  4'h0
`define SP_RST     8'h00
`define PC_RST     12'h000
`define PC_ONE     12'h001
`define SP_STEP    8'h02
`define BYTE_ONE   8'h01
`define BYTE_ZERO  8'h00

`endif

// ==== verif/skip_ctl_chk.sv ====
// checker for the skip and control-flow execution block
// assumes binding to the block top; sees only its ports
`timescale 1ns/100ps
`include "skip_ctl_regs.vh"

module skip_ctl_chk (
  // clock and reset
  input wire        clock,
  input wire        rst,
  // instruction port
  input wire        op_valid,
  input wire [3:0]  op_code,
  input wire        op_ready,
  input wire [7:0]  imm,
  input wire [11:0] target,
  // side effects
  input wire        mem_we,
  input wire        stk_we,
  input wire        stk_re,
  input wire [7:0]  stk_addr,
  input wire [11:0] stk_wdata,
  input wire [11:0] stk_rdata,
  input wire        wdt_clear,
  input wire        gie_set,
  input wire        op_done,
  input wire        skipped,
  // core state
  input wire [7:0]  acc,
  input wire [3:0]  flags,
  input wire [7:0]  sp,
  input wire [11:0] pc
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // instruction accepted at this edge
  wire take = op_valid && op_ready;
  // any of the three returns
  wire is_ret = op_code == `OP_RET || op_code == `OP_RETV ||
                op_code == `OP_IRET;

  // a squashed instruction is excused through skipped
  chk_call_push: assert property (take && op_code == `OP_CALL |=>
    skipped || (stk_we && stk_addr == $past(sp) && sp == $past(sp) + 8'h02
    && stk_wdata == $past(pc) + 12'h001 && pc == $past(target)))
    else $error("call push wrong");
  chk_goto_load: assert property (take && op_code == `OP_GOTO |=>
    skipped || (pc == $past(target) && $stable(flags) && !stk_we))
    else $error("jump wrong");
  chk_ret_pop: assert property (take && is_ret |=> skipped or
    (stk_re && !op_ready && sp == $past(sp) - 8'h02 && stk_addr == sp &&
    $stable(flags) ##1 op_done && pc == $past(stk_rdata) && $stable(flags)))
    else $error("return pop wrong");
  chk_retv_acc: assert property (take && op_code == `OP_RETV |=>
    skipped or (##1 acc == $past(imm, 2)))
    else $error("return value wrong");
  chk_iret_gie: assert property (take && op_code == `OP_IRET |=>
    skipped or (!gie_set ##1 gie_set))
    else $error("interrupt enable late");
  chk_wdt_clear: assert property (take && op_code == `OP_WDRST |=>
    skipped || (wdt_clear && $stable(flags)))
    else $error("watchdog clear missing");
  chk_bit_keep: assert property (take && (op_code == `OP_BCLR ||
    op_code == `OP_BSET) |=> $stable(flags) && $stable(acc) && !mem_we)
    else $error("bit test changed state");
  chk_squash_quiet: assert property (skipped |-> op_done && !mem_we &&
    !stk_we && !stk_re && !gie_set && !wdt_clear && $stable(acc) &&
    $stable(flags) && $stable(sp))
    else $error("squash had effects");
  chk_nop_keep: assert property (take && op_code == `OP_NOP |=>
    op_done && $stable(acc) && $stable(sp) && $stable(flags) &&
    pc == $past(pc) + 12'h001)
    else $error("no-op changed state");

  // main scenarios reached
  cover property (take && op_code == `OP_CALL);
  cover property (skipped);
  cover property (gie_set);
endmodule

bind skip_and_control_flow_exec skip_ctl_chk chk (.clock, .rst, .op_valid,
  .op_code, .op_ready, .imm, .target, .mem_we, .stk_we, .stk_re, .stk_addr,
  .stk_wdata, .stk_rdata, .wdt_clear, .gie_set, .op_done, .skipped, .acc,
  .flags, .sp, .pc);

// ==== verif/skip_and_control_flow_exec_tb.sv ====
// self-checking bench for the skip and control-flow execution block
// assumes the block header on the include path, clock at 200 MHz
`timescale 1ns/100ps
`include "skip_ctl_regs.vh"

module skip_and_control_flow_exec_tb;
  // stimulus
  logic        clock, rst, op_valid, op_mem, we, re;
  logic [3:0]  op_code, addr;
  logic [7:0]  imm, opnd, mem_addr, wdata;
  logic [2:0]  bit_sel;
  logic [11:0] target;
  // observation
  wire         op_ready, mem_we, stk_we, stk_re, wdt_clear, gie_set;
  wire         op_done, skipped;
  wire  [7:0]  mem_waddr, mem_wdata, stk_addr, acc, sp, rdata;
  wire  [11:0] stk_wdata, stk_rdata, pc;
  wire  [3:0]  flags;
  // stack seen by the block, and the bench's own copy
  logic [11:0] stk [0:127];
  logic [11:0] ms  [0:127];
  // expected core state
  logic [7:0]  m_acc, m_sp;
  logic [11:0] m_pc;
  logic [3:0]  m_f;
  logic        m_sk;
  logic [31:0] v;
  integer      n_fail, n_compared, seed, k;

  skip_and_control_flow_exec dut (.clock, .rst, .op_valid, .op_code, .op_mem,
    .imm, .opnd, .bit_sel, .target, .mem_addr, .op_ready, .mem_we,
    .mem_waddr, .mem_wdata, .stk_we, .stk_re, .stk_addr, .stk_wdata,
    .stk_rdata, .wdt_clear, .gie_set, .op_done, .skipped, .acc, .flags,
    .sp, .pc, .addr, .wdata, .we, .re, .rdata);

  // stack answers only while read; inverted otherwise so stale data shows
  assign stk_rdata = stk_re ? stk[stk_addr[7:1]] : ~stk[stk_addr[7:1]];
  always @(posedge clock) begin
    if (stk_we)
      stk[stk_addr[7:1]] <= stk_wdata;
  end

  // 5 ns clock
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  // flags {ov, ac, c, z} of a plus or minus b; c is borrow on minus
  function automatic [3:0] flg(input [7:0] a, input [7:0] b, input s);
    logic [8:0] r;
    logic [4:0] n;
    begin
      r = s ? {1'h0, a} - {1'h0, b} : {1'h0, a} + {1'h0, b};
      n = s ? {1'h0, a[3:0]} - b[3:0] : {1'h0, a[3:0]} + b[3:0];
      flg = {((a[7] ^ b[7]) == s) && (r[7] != a[7]), n[4], r[8],
             r[7:0] == 8'h00};
    end
  endfunction

  // one comparison, counted
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  task tally_and_finish;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // register port: one-cycle strobes
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    {we, addr, wdata} <= {1'h1, a, d};
    @(posedge clock);
    we <= 1'h0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    {re, addr} <= {1'h1, a};
    @(posedge clock);
    re <= 1'h0;
    #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask

  // issue one instruction, predict, wait for done, compare
  task op(input logic [3:0] c, input logic m, input logic [7:0] i, o,
          input logic [2:0] b, input logic [11:0] t);
    logic [7:0] s, r;
    logic [3:0] ev, sv;
    logic       sq;
    begin
      s = m ? o : m_acc;
      r = c == `OP_DECZ ? s - 8'h01 : s + 8'h01;
      ev = 4'h0;
      sq = m_sk;
      m_sk = 1'h0;
      m_pc = m_pc + 12'h001;
      // a pending skip squashes this one whatever it is
      if (!sq)
        case (c)
          `OP_CEQ, `OP_CNE: begin
            m_f = flg(m_acc, m ? o : i, 1'h1);
            m_sk = (m_acc == (m ? o : i)) == (c == `OP_CEQ);
          end
          `OP_BCLR, `OP_BSET: m_sk = o[b] == (c == `OP_BSET);
          `OP_INCZ, `OP_DECZ: begin
            m_f = flg(s, 8'h01, c == `OP_DECZ);
            m_sk = r == 8'h00;
            if (m) ev[2] = 1'h1;
            else m_acc = r;
          end
          `OP_CALL: begin
            ms[m_sp[7:1]] = m_pc;
            m_sp = m_sp + 8'h02;
            m_pc = t;
          end
          `OP_GOTO: m_pc = t;
          `OP_RETV, `OP_RET, `OP_IRET: begin
            if (c == `OP_RETV) m_acc = i;
            m_sp = m_sp - 8'h02;
            m_pc = ms[m_sp[7:1]];
            ev[1] = c == `OP_IRET;
          end
          `OP_WDRST: ev[0] = 1'h1;
          default: ;
        endcase
      ev[3] = sq;
      @(posedge clock);
      {op_valid, op_code, op_mem, imm, opnd, bit_sel, target, mem_addr}
        <= {1'h1, c, m, i, o, b, t, i};
      @(posedge clock);
      op_valid <= 1'h0;
      sv = 4'h0;
      // pulses {skipped, mem_we, gie_set, wdt_clear} up to done
      for (k = 0; k < 4; k++) begin
        #1 sv = sv | {skipped, mem_we, gie_set, wdt_clear};
        if (op_done === 1'h1) break;
        @(posedge clock);
      end
      if (k == 4) begin
        n_fail++;
        tally_and_finish;
      end
      chk("pc", m_pc, pc);
      chk("acc", m_acc, acc);
      chk("flags", m_f, flags);
      chk("sp", m_sp, sp);
      chk("events", ev, sv);
      if (ev[2]) chk("mem", {i, r}, {mem_waddr, mem_wdata});
    end
  endtask

  // main sequence: corners first, then a seeded random stream
  initial begin
    seed = 43768;
    n_fail = 0;
    n_compared = 0;
    {rst, op_valid, we, re} = 4'h8;
    {op_code, op_mem, imm, opnd, bit_sel, target, mem_addr} = '0;
    {addr, wdata, m_acc, m_sp, m_pc, m_f, m_sk} = '0;
    for (k = 0; k < 128; k++) begin
      stk[k] = 12'h000;
      ms[k] = 12'h000;
    end
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    for (k = 0; k < 6; k++) rd(k[3:0], 8'h00);
    rd(4'hF, 8'h00);
    wr(`REG_FLAGS, 8'hFF);
    rd(`REG_FLAGS, 8'h0F);
    wr(`REG_PC_LO, 8'hFE);
    wr(`REG_PC_HI, 8'hFF);
    rd(`REG_PC_HI, 8'h0F);
    wr(`REG_ACC, 8'hFF);
    {m_f, m_pc, m_acc} = {4'hF, 12'hFFE, 8'hFF};
    op(`OP_BSET, 1'h1, 8'h00, 8'h20, 3'h5, 12'h000);
    op(`OP_INCZ, 1'h0, 8'h00, 8'h00, 3'h0, 12'h000);
    op(`OP_INCZ, 1'h0, 8'h00, 8'h00, 3'h0, 12'h000);
    op(`OP_CALL, 1'h0, 8'h00, 8'h00, 3'h0, 12'h123);
    op(`OP_DECZ, 1'h0, 8'h00, 8'h00, 3'h0, 12'h000);
    op(`OP_CALL, 1'h0, 8'h00, 8'h00, 3'h0, 12'hABC);
    op(`OP_CALL, 1'h0, 8'h00, 8'h00, 3'h0, 12'h456);
    op(`OP_IRET, 1'h0, 8'h00, 8'h00, 3'h0, 12'h000);
    op(`OP_RETV, 1'h0, 8'h5A, 8'h00, 3'h0, 12'h000);
    op(`OP_WDRST, 1'h0, 8'h00, 8'h00, 3'h0, 12'h000);
    op(`OP_BCLR, 1'h1, 8'h00, 8'hFE, 3'h0, 12'h000);
    rd(`REG_STAT, 8'h01);
    op(`OP_RET, 1'h0, 8'h00, 8'h00, 3'h0, 12'h000);
    rd(`REG_ACC, m_acc);
    rd(`REG_PC_LO, m_pc[7:0]);
    // move the stack away from zero before the random stream
    wr(`REG_SP, 8'h10);
    rd(`REG_SP, 8'h10);
    m_sp = 8'h10;
    repeat (400) begin
      v = $random(seed);
      op(v[3:0], v[4], v[5] ? m_acc : v[15:8], v[7:6] == 2'h0 ? 8'hFF :
         v[7:6] == 2'h1 ? 8'h01 : v[23:16], v[26:24], v[31:20]);
    end
    tally_and_finish;
  end
endmodule
